// ===== design/wspe_consts.svh
/*
   Constants of the wheel-speed pulse encoder: timing figures, derived cycle
   counts, register offsets, field positions and reset values.
   Assumes a single 250 MHz clock; included by bare name.
*/
// Overview of operation
// - After each accepted edge hold the output low for the 45 us gap.
// - After the gap drive the output high for the chosen width, then low.
// - Strong field: 90 us pulse for left, 180 us for right rotation.
// - Weak field above warning: 360 us left, 720 us right, marking assembly position.
// - Above about 117 Hz the weak field falls back to 90/180 us pulses.
// - Field below warning threshold: every pulse is 45 us long.
// - Warning width overrides all other codes, hiding direction and position.
// - Below the loss threshold no valid speed pulses are required.
// - No edge for 737 ms: emit a 1.44 ms standstill pulse.
// - The standstill pulse returns the encoder to the uncalibrated state.
// - Output stays disabled until calibration after power-up or standstill finishes.
// - A new edge may cut the running pulse short within one period.
// - Calibration completes after at most six magnetic edges.
// - Recalibrate every 0.7 s while stationary; 300 us each, edges ignored.
`ifndef WSPE_CONSTS_SVH
`define WSPE_CONSTS_SVH

// ==========================================================================
// Clock and timing figures
`define WSPE_CLK_MHZ            250
`define WSPE_CLK_HZ             250000000
`define WSPE_T_PRELOW_US        45
`define WSPE_T_WARN_US          45
`define WSPE_T_DIR_L_US         90
`define WSPE_T_DIR_R_US         180
`define WSPE_T_EL_L_US          360
`define WSPE_T_EL_R_US          720
`define WSPE_T_STOP_PULSE_MS    1.44
`define WSPE_T_STOP_PERIOD_MS   737
`define WSPE_T_RECAL_S          0.7
`define WSPE_T_CAL_US           300
`define WSPE_ASSEMBLY_CODE_MAX_RATE_HZ        117
`define WSPE_CAL_EDGES          6

// ==========================================================================
// Derived cycle counts
`define WSPE_CYC_US(t)          ((t) * `WSPE_CLK_MHZ)
`define WSPE_CYC_MS(t)          (int'((t) * 1000.0 * `WSPE_CLK_MHZ))
`define WSPE_CYC_S(t)           (int'((t) * 1000000.0 * `WSPE_CLK_MHZ))
// Least edge spacing (half signal period) that still allows long pulses
`define WSPE_EL_MIN_GAP_CYC     ((`WSPE_CLK_HZ + 2 * `WSPE_ASSEMBLY_CODE_MAX_RATE_HZ - 1) / (2 * `WSPE_ASSEMBLY_CODE_MAX_RATE_HZ))

// ==========================================================================
// Register map
`define WSPE_ADDR_CTRL          4'h0
`define WSPE_ADDR_STATUS        4'h4
`define WSPE_ADDR_IRQ_STAT      4'h8
`define WSPE_ADDR_IRQ_MASK      4'hc
`define WSPE_CTRL_EN_BIT        0
`define WSPE_CTRL_RST           1'h1
`define WSPE_MASK_RST           4'h0
`define WSPE_IRQ_STOP_BIT       0
`define WSPE_IRQ_WARN_BIT       1
`define WSPE_IRQ_LOST_BIT       2
`define WSPE_IRQ_CAL_BIT        3

`endif

// ===== design/wspe_pkg.sv
/*
   Types shared by the wheel-speed pulse encoder modules.
   Assumes nothing of its surroundings.
*/
package wspe_pkg;
   // Amplitude class from the sensing front end
   typedef enum logic [1:0] {
      WSPE_AMP_STRONG  = 2'h0,
      WSPE_AMP_INSTALL = 2'h1,
      WSPE_AMP_WARN    = 2'h2,
      WSPE_AMP_LOST    = 2'h3
   } wspe_amp_t;

   typedef enum logic [5:0] {
      WSPE_ST_CALIB = 6'h01,
      WSPE_ST_UNCAL = 6'h02,
      WSPE_ST_IDLE  = 6'h04,
      WSPE_ST_GAP   = 6'h08,
      WSPE_ST_PULSE = 6'h10,
      WSPE_ST_STOP  = 6'h20
   } wspe_state_t;

   typedef logic [27:0] wspe_cnt_t;
endpackage

// ===== design/wspe_tmr_if.sv
/*
   Interface between the encoder sequencer and its phase timer.
   Assumes both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface wspe_tmr_if;
   logic                load;
   wspe_pkg::wspe_cnt_t load_val;
   wspe_pkg::wspe_cnt_t remain;
   logic                done;
   modport ctrl (output load, output load_val, input remain, input done);
   modport tmr  (input load, input load_val, output remain, output done);
endinterface
`default_nettype wire

// ===== design/wspe_timer.sv
/*
   Phase timer: a loadable down counter that flags its last cycle.
   Assumes a synchronised active-low reset from the top module.
*/
`timescale 1ns/1ps
`default_nettype none
module wspe_timer
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Sequencer side
   wspe_tmr_if.tmr  tmr
);
   import wspe_pkg::*;

   wspe_cnt_t remain;
   wspe_cnt_t next_remain;

   // ======================================================================
   // Count down
   always_comb
   begin
      next_remain = remain;
      if (tmr.load)
         next_remain = tmr.load_val;
      else if (remain != '0)
         next_remain = remain - 28'h1;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         remain <= '0;
      else
         remain <= next_remain;
   end

   assign tmr.remain = remain;
   assign tmr.done   = (remain == 28'h1);
endmodule // wspe_timer
`default_nettype wire

// ===== design/wspe_encoder.sv
/*
   Wheel-speed pulse encoder: turns front-end edge strobes into gap and
   pulse sequences on the current-level output, with calibration,
   standstill pulse, a small register port and one interrupt.
   Assumes front-end inputs synchronous to clock and a plain register master.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wspe_consts.svh"
module wspe_encoder
#(
   parameter int PRELOW_CYC      = `WSPE_CYC_US(`WSPE_T_PRELOW_US),
   parameter int WARN_CYC        = `WSPE_CYC_US(`WSPE_T_WARN_US),
   parameter int DIR_L_CYC       = `WSPE_CYC_US(`WSPE_T_DIR_L_US),
   parameter int DIR_R_CYC       = `WSPE_CYC_US(`WSPE_T_DIR_R_US),
   parameter int EL_L_CYC        = `WSPE_CYC_US(`WSPE_T_EL_L_US),
   parameter int EL_R_CYC        = `WSPE_CYC_US(`WSPE_T_EL_R_US),
   parameter int STOP_PULSE_CYC  = `WSPE_CYC_MS(`WSPE_T_STOP_PULSE_MS),
   parameter int STOP_PERIOD_CYC = `WSPE_CYC_MS(`WSPE_T_STOP_PERIOD_MS),
   parameter int RECAL_CYC       = `WSPE_CYC_S(`WSPE_T_RECAL_S),
   parameter int CAL_CYC         = `WSPE_CYC_US(`WSPE_T_CAL_US),
   parameter int EL_MIN_GAP_CYC  = `WSPE_EL_MIN_GAP_CYC,
   parameter int CAL_EDGES       = `WSPE_CAL_EDGES
)
(
   // Clock and reset
   input  wire logic                clock,
   input  wire logic                arst_n,
   // Sensing front end
   input  wire logic                edge_strobe,
   input  wire logic                dir_right,
   input  wire wspe_pkg::wspe_amp_t amp_class,
   // Current-level output
   output var  logic                current_high,
   output var  logic                speed_valid,
   // Register port
   input  wire logic [3:0]          reg_addr,
   input  wire logic [31:0]         reg_wdata,
   input  wire logic                reg_write,
   input  wire logic                reg_read,
   output var  logic [31:0]         reg_rdata,
   // Interrupt
   output var  logic                irq
);
   import wspe_pkg::*;

   localparam wspe_cnt_t PRELOW_C  = wspe_cnt_t'(PRELOW_CYC);
   localparam wspe_cnt_t WARN_C    = wspe_cnt_t'(WARN_CYC);
   localparam wspe_cnt_t DIR_L_C   = wspe_cnt_t'(DIR_L_CYC);
   localparam wspe_cnt_t DIR_R_C   = wspe_cnt_t'(DIR_R_CYC);
   localparam wspe_cnt_t EL_L_C    = wspe_cnt_t'(EL_L_CYC);
   localparam wspe_cnt_t EL_R_C    = wspe_cnt_t'(EL_R_CYC);
   localparam wspe_cnt_t STOP_PL_C = wspe_cnt_t'(STOP_PULSE_CYC);
   localparam wspe_cnt_t STOP_PD_C = wspe_cnt_t'(STOP_PERIOD_CYC);
   localparam wspe_cnt_t RECAL_C   = wspe_cnt_t'(RECAL_CYC);
   localparam wspe_cnt_t CAL_C     = wspe_cnt_t'(CAL_CYC);
   localparam wspe_cnt_t EL_GAP_C  = wspe_cnt_t'(EL_MIN_GAP_CYC);
   localparam logic [2:0] CAL_LAST = 3'(CAL_EDGES - 1);

   // ======================================================================
   // Reset release
   logic rst_meta;
   logic rst_sync;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // ======================================================================
   // Pulse width selection
   function automatic wspe_cnt_t sel_width(input wspe_amp_t amp, input logic right,
                                           input logic slow);
      sel_width = right ? DIR_R_C : DIR_L_C;
      if (amp == WSPE_AMP_WARN)
         sel_width = WARN_C;
      else if (amp == WSPE_AMP_INSTALL && slow)
         sel_width = right ? EL_R_C : EL_L_C;
   endfunction

   // ======================================================================
   // Sequencer
   wspe_tmr_if  tmr ();
   wspe_state_t state;
   wspe_state_t next_state;
   wspe_cnt_t   pulse_len;
   wspe_cnt_t   next_pulse_len;
   wspe_cnt_t   quiet;
   wspe_cnt_t   next_quiet;
   logic [2:0]  cal_cnt;
   logic [2:0]  next_cal_cnt;
   logic        next_current_high;
   logic        next_speed_valid;
   logic        edge_ok;
   logic        coding;
   logic        ctrl_en;

   wspe_timer u_timer
   (
      .clock (clock),
      .rst_n (rst_sync),
      .tmr   (tmr.tmr)
   );

   // Lost-signal edges carry no usable timing, so they are not encoded
   assign edge_ok = edge_strobe && (amp_class != WSPE_AMP_LOST);
   assign coding  = (state == WSPE_ST_IDLE) || (state == WSPE_ST_GAP) ||
                    (state == WSPE_ST_PULSE);

   always_comb
   begin
      next_state     = state;
      next_pulse_len = pulse_len;
      next_cal_cnt   = cal_cnt;
      next_quiet     = (quiet == '1) ? quiet : quiet + 28'h1;
      if (edge_ok && state != WSPE_ST_CALIB)
         next_quiet = '0;
      unique case (state)
         WSPE_ST_CALIB:
         begin
            // Edges during calibration are ignored
            next_cal_cnt = '0;
            next_quiet   = '0;
            if (tmr.done)
               next_state = WSPE_ST_UNCAL;
         end
         WSPE_ST_UNCAL:
         begin
            if (edge_ok)
            begin
               next_cal_cnt = cal_cnt + 3'h1;
               if (cal_cnt == CAL_LAST)
                  next_state = WSPE_ST_IDLE;
            end
            else if (quiet >= RECAL_C)
               next_state = WSPE_ST_CALIB;
         end
         WSPE_ST_IDLE:
         begin
            if (edge_ok)
               next_state = WSPE_ST_GAP;
            else if (quiet >= STOP_PD_C)
               next_state = WSPE_ST_STOP;
         end
         WSPE_ST_GAP:
         begin
            if (!edge_ok && tmr.done)
               next_state = WSPE_ST_PULSE;
         end
         WSPE_ST_PULSE:
         begin
            // A fresh edge cuts the running pulse and restarts the gap
            if (edge_ok)
               next_state = WSPE_ST_GAP;
            else if (tmr.done)
               next_state = WSPE_ST_IDLE;
         end
         WSPE_ST_STOP:
         begin
            if (tmr.done)
               next_state = WSPE_ST_CALIB;
         end
      endcase
      if (edge_ok && coding)
         next_pulse_len = sel_width(amp_class, dir_right, quiet >= EL_GAP_C);
      next_current_high = ctrl_en && (next_state == WSPE_ST_PULSE ||
                                      next_state == WSPE_ST_STOP);
      next_speed_valid  = (next_state != WSPE_ST_CALIB) && (next_state != WSPE_ST_UNCAL);
   end

   // Timer reload on each timed phase entry, and once after reset
   always_comb
   begin
      tmr.load     = 1'b0;
      tmr.load_val = CAL_C;
      if ((next_state != state) || (edge_ok && coding) ||
          (state == WSPE_ST_CALIB && tmr.remain == '0))
      begin
         tmr.load = 1'b1;
         unique case (next_state)
            WSPE_ST_GAP:   tmr.load_val = PRELOW_C;
            WSPE_ST_PULSE: tmr.load_val = pulse_len;
            WSPE_ST_STOP:  tmr.load_val = STOP_PL_C;
            default:       tmr.load_val = CAL_C;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         state        <= WSPE_ST_CALIB;
         pulse_len    <= '0;
         quiet        <= '0;
         cal_cnt      <= '0;
         current_high <= 1'b0;
         speed_valid  <= 1'b0;
      end
      else
      begin
         state        <= next_state;
         pulse_len    <= next_pulse_len;
         quiet        <= next_quiet;
         cal_cnt      <= next_cal_cnt;
         current_high <= next_current_high;
         speed_valid  <= next_speed_valid;
      end
   end

   // ======================================================================
   // Registers and interrupt
   logic [3:0]  irq_stat;
   logic [3:0]  next_irq_stat;
   logic [3:0]  irq_mask;
   logic [3:0]  next_irq_mask;
   logic [3:0]  events;
   logic        next_ctrl_en;
   logic        next_irq;
   logic [31:0] next_reg_rdata;

   always_comb
   begin
      events = '0;
      events[`WSPE_IRQ_STOP_BIT] = (state == WSPE_ST_IDLE) && (next_state == WSPE_ST_STOP);
      events[`WSPE_IRQ_WARN_BIT] = edge_ok && coding && (amp_class == WSPE_AMP_WARN);
      events[`WSPE_IRQ_LOST_BIT] = edge_strobe && (amp_class == WSPE_AMP_LOST);
      events[`WSPE_IRQ_CAL_BIT]  = (state == WSPE_ST_UNCAL) && (next_state == WSPE_ST_IDLE);
      next_ctrl_en  = ctrl_en;
      next_irq_mask = irq_mask;
      next_irq_stat = irq_stat;
      if (reg_write && reg_addr == `WSPE_ADDR_CTRL)
         next_ctrl_en = reg_wdata[`WSPE_CTRL_EN_BIT];
      if (reg_write && reg_addr == `WSPE_ADDR_IRQ_MASK)
         next_irq_mask = reg_wdata[3:0];
      if (reg_write && reg_addr == `WSPE_ADDR_IRQ_STAT)
         next_irq_stat = irq_stat & ~reg_wdata[3:0];
      // A new event wins over a clear in the same cycle
      next_irq_stat = next_irq_stat | events;
      next_irq      = |(next_irq_stat & next_irq_mask);
      next_reg_rdata = '0;
      if (reg_read)
      begin
         unique case (reg_addr)
            `WSPE_ADDR_CTRL:     next_reg_rdata = {31'h0, ctrl_en};
            `WSPE_ADDR_STATUS:   next_reg_rdata = {21'h0, cal_cnt, state, speed_valid,
                                                   current_high};
            `WSPE_ADDR_IRQ_STAT: next_reg_rdata = {28'h0, irq_stat};
            `WSPE_ADDR_IRQ_MASK: next_reg_rdata = {28'h0, irq_mask};
            default:             next_reg_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         ctrl_en   <= `WSPE_CTRL_RST;
         irq_mask  <= `WSPE_MASK_RST;
         irq_stat  <= '0;
         irq       <= 1'b0;
         reg_rdata <= '0;
      end
      else
      begin
         ctrl_en   <= next_ctrl_en;
         irq_mask  <= next_irq_mask;
         irq_stat  <= next_irq_stat;
         irq       <= next_irq;
         reg_rdata <= next_reg_rdata;
      end
   end

   // ======================================================================
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_sync);

   sequence s_gap_end;
      state == WSPE_ST_GAP && tmr.done && !edge_ok;
   endsequence

   sequence s_stop_end;
      state == WSPE_ST_STOP && tmr.done;
   endsequence

   chk_gap_low_out: assert property (state == WSPE_ST_GAP |-> !current_high)
      else $error("output high during gap");

   chk_gap_load_len: assert property (edge_ok && coding |=> state == WSPE_ST_GAP
                                      && tmr.remain == PRELOW_C)
      else $error("gap not started with its full length");

   chk_gap_to_pulse: assert property (s_gap_end |=> state == WSPE_ST_PULSE
                                      && tmr.remain == pulse_len
                                      && current_high == ctrl_en)
      else $error("pulse did not follow the gap");

   chk_strong_width: assert property (edge_ok && coding && amp_class == WSPE_AMP_STRONG
                                      |=> pulse_len == ($past(dir_right) ? DIR_R_C
                                                                         : DIR_L_C))
      else $error("wrong direction pulse width");

   chk_install_width: assert property (edge_ok && coding && amp_class == WSPE_AMP_INSTALL
                                       && quiet >= EL_GAP_C
                                       |=> pulse_len == ($past(dir_right) ? EL_R_C : EL_L_C))
      else $error("wrong assembly pulse width");

   chk_fast_fallback: assert property (edge_ok && coding && amp_class == WSPE_AMP_INSTALL
                                       && quiet < EL_GAP_C
                                       |=> pulse_len == ($past(dir_right) ? DIR_R_C : DIR_L_C))
      else $error("long pulse above rate limit");

   chk_warn_width: assert property (edge_ok && coding && amp_class == WSPE_AMP_WARN
                                    |=> pulse_len == WARN_C)
      else $error("warning pulse width wrong");

   chk_standstill_go: assert property (state == WSPE_ST_IDLE && !edge_ok && quiet >= STOP_PD_C
                                       |=> state == WSPE_ST_STOP
                                       && tmr.remain == STOP_PL_C)
      else $error("standstill pulse missing");

   chk_stop_recal: assert property (s_stop_end |=> state == WSPE_ST_CALIB ##1
                                    tmr.remain == CAL_C - 28'h1)
      else $error("no recalibration after standstill");

   chk_cal_quiet: assert property (!speed_valid |-> !current_high || state == WSPE_ST_STOP)
      else $error("output active while uncalibrated");

   chk_cal_edges: assert property (state == WSPE_ST_UNCAL && edge_ok && cal_cnt == CAL_LAST
                                   |=> state == WSPE_ST_IDLE && speed_valid)
      else $error("calibration not done after edge count");

   chk_irq_level: assert property (##1 irq == |($past(next_irq_stat) & $past(next_irq_mask)))
      else $error("interrupt level mismatch");
endmodule // wspe_encoder
`default_nettype wire

// ===== tb/wspe_rx_model.sv
/*
   Far-side receiver model: measures the length of each high-current pulse.
   Assumes the line level is sampled on the encoder clock.
*/
`timescale 1ns/1ps
`default_nettype none
module wspe_rx_model
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // Current line
   input  wire logic        current_high,
   // Measurements
   output var  logic [15:0] width,
   output var  logic [15:0] pulse_cnt,
   output var  logic        dir_trusted
);
   logic [15:0] run;
   logic        prev;
   // ==========================================================
   // Pulse measurement
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         run       <= 16'h0000;
         prev      <= 1'b0;
         width     <= 16'h0000;
         pulse_cnt <= 16'h0000;
      end
      else
      begin
         prev <= current_high;
         run  <= current_high ? run + 16'h0001 : 16'h0000;
         // Any width, the standstill pulse included, is accepted as it comes
         if (prev && !current_high)
         begin
            width     <= run;
            pulse_cnt <= pulse_cnt + 16'h0001;
         end
      end
   end
   // Direction is not believed before four pulses have passed
   assign dir_trusted = (pulse_cnt > 16'h0003);
endmodule // wspe_rx_model
`default_nettype wire

// ===== tb/wspe_encoder_tb_top.sv
/*
   Self-checking testbench of the wheel-speed pulse encoder.
   Assumes shortened timing parameters and the receiver model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module wspe_encoder_tb_top;
   import wspe_pkg::*;
   localparam int PRELOW = 4, WARN = 4, DIR_L = 8, DIR_R = 12, EL_L = 16, EL_R = 20;
   localparam int STOP_P = 30, STOP_T = 300, RECAL = 400, CAL = 10, EL_GAP = 50;
   logic        clock, arst_n, edge_strobe, dir_right, reg_write, reg_read;
   wspe_amp_t   amp_class;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rng, rd;
   logic        current_high, speed_valid, irq, dir_trusted;
   logic [15:0] width, pulse_cnt;
   int          num_errors, check_count, since, n;
   // ==========================================================
   // Instances
   wspe_encoder #(.PRELOW_CYC(PRELOW), .WARN_CYC(WARN), .DIR_L_CYC(DIR_L), .DIR_R_CYC(DIR_R),
      .EL_L_CYC(EL_L), .EL_R_CYC(EL_R), .STOP_PULSE_CYC(STOP_P), .STOP_PERIOD_CYC(STOP_T),
      .RECAL_CYC(RECAL), .CAL_CYC(CAL), .EL_MIN_GAP_CYC(EL_GAP)) i_wspe_encoder (
      .clock(clock), .arst_n(arst_n), .edge_strobe(edge_strobe), .dir_right(dir_right),
      .amp_class(amp_class), .current_high(current_high), .speed_valid(speed_valid),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));
   wspe_rx_model i_wspe_rx_model (.clock(clock), .rst_n(arst_n), .current_high(current_high),
      .width(width), .pulse_cnt(pulse_cnt), .dir_trusted(dir_trusted));
   // ==========================================================
   // Clock, edge spacing, watchdog
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   always @(posedge clock) since <= edge_strobe ? 0 : since + 1;
   initial
   begin
      #(20000 * 4);
      num_errors++;
      print_verdict();
   end
   // ==========================================================
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic int exp_w(input logic d, input wspe_amp_t a, input int sp);
      if (a == WSPE_AMP_WARN) return WARN;
      if (a == WSPE_AMP_INSTALL && sp >= EL_GAP) return d ? EL_R : EL_L;
      return d ? DIR_R : DIR_L;
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      check_count++;
      if ((got >= lo && got <= hi) !== 1'b1)
      begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, lo);
      end
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      repeat (2) @(posedge clock);
   endtask
   task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic drive_edge(input logic d, input wspe_amp_t a);
      @(posedge clock);
      edge_strobe <= 1'b1;
      dir_right   <= d;
      amp_class   <= a;
      @(posedge clock);
      edge_strobe <= 1'b0;
   endtask
   task automatic wait_cnt(input logic [15:0] c0);
      n = 0;
      while (pulse_cnt === c0 && n < 2000)
      begin
         @(posedge clock);
         #1 n++;
      end
      // A pulse that never ends counts as a mismatch
      if (n >= 2000)
      begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, pulse_cnt, c0);
      end
   endtask
   task automatic pulse(input logic d, input wspe_amp_t a, input int idle);
      logic [31:0] g, ew;
      logic [15:0] c0;
      repeat (idle) @(posedge clock);
      // Keep clear of the long-pulse rate boundary
      if (since > EL_GAP - 6 && since < EL_GAP + 6) repeat (12) @(posedge clock);
      ew = exp_w(d, a, since);
      c0 = pulse_cnt;
      drive_edge(d, a);
      g = 0;
      while (current_high !== 1'b1 && g < 100)
      begin
         @(posedge clock);
         #1 g++;
      end
      check_rng(g, PRELOW, PRELOW + 3);
      wait_cnt(c0);
      check_rng({16'h0000, width}, ew, ew + 2);
   endtask
   task automatic calibrate();
      repeat (5) begin drive_edge(1'b0, WSPE_AMP_STRONG); repeat (20) @(posedge clock); end
      check(speed_valid, 1'b0);
      drive_edge(1'b1, WSPE_AMP_STRONG);
      repeat (3) @(posedge clock);
      check(speed_valid, 1'b1);
      check(current_high, 1'b0);
   endtask
   task automatic print_verdict();
      $display("errors=%0d checks=%0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ==========================================================
   // Main sequence
   initial
   begin
      {arst_n, edge_strobe, dir_right, reg_write, reg_read} = 5'h00;
      amp_class = WSPE_AMP_STRONG;
      {reg_addr, reg_wdata} = 36'h0;
      rng = 32'h0000b8e1;
      repeat (5) @(posedge clock);
      arst_n <= 1'b1;
      repeat (3) @(posedge clock);
      reg_rd(4'h0, rd);
      check(rd[0], 1'b1);
      reg_rd(4'hc, rd);
      check(rd, 32'h0);
      reg_rd(4'h2, rd);
      check(rd, 32'h0);
      check(speed_valid, 1'b0);
      drive_edge(1'b0, WSPE_AMP_STRONG);
      repeat (CAL + 5) @(posedge clock);
      calibrate();
      reg_rd(4'h4, rd);
      check(rd, 32'h00000612);
      check(dir_trusted, 1'b0);
      pulse(1'b0, WSPE_AMP_STRONG, 30);
      pulse(1'b1, WSPE_AMP_STRONG, 30);
      pulse(1'b0, WSPE_AMP_INSTALL, 60);
      pulse(1'b1, WSPE_AMP_INSTALL, 60);
      pulse(1'b0, WSPE_AMP_INSTALL, 0);
      pulse(1'b1, WSPE_AMP_INSTALL, 0);
      pulse(1'b1, WSPE_AMP_WARN, 60);
      pulse(1'b0, WSPE_AMP_WARN, 10);
      check(dir_trusted, 1'b1);
      // Interrupt: masked, unmasked, cleared
      reg_rd(4'h8, rd);
      check(rd[1], 1'b1);
      check(irq, 1'b0);
      reg_wr(4'hc, 32'h2);
      check(irq, 1'b1);
      reg_wr(4'h8, 32'hf);
      check(irq, 1'b0);
      rd[15:0] = pulse_cnt;
      drive_edge(1'b0, WSPE_AMP_LOST);
      repeat (30) @(posedge clock);
      check(pulse_cnt, rd[15:0]);
      // Output disabled by control: edge is timed but no current pulse
      reg_wr(4'h0, 32'h0);
      drive_edge(1'b0, WSPE_AMP_STRONG);
      repeat (30) @(posedge clock);
      check(pulse_cnt, rd[15:0]);
      reg_wr(4'h0, 32'h1);
      reg_wr(4'hc, 32'h4);
      check(irq, 1'b1);
      reg_wr(4'h8, 32'h4);
      check(irq, 1'b0);
      // A new edge while the pulse is high cuts it and restarts the gap
      drive_edge(1'b0, WSPE_AMP_STRONG);
      n = 0;
      while (current_high !== 1'b1 && n < 100) begin @(posedge clock); #1 n++; end
      repeat (2) @(posedge clock);
      drive_edge(1'b1, WSPE_AMP_STRONG);
      repeat (2) @(posedge clock);
      #1 check(current_high, 1'b0);
      check_rng({16'h0000, width}, 1, DIR_L - 1);
      wait_cnt(pulse_cnt);
      check_rng({16'h0000, width}, DIR_R, DIR_R + 2);
      repeat (24)
      begin
         rng = xs(rng);
         pulse(rng[0], (rng[2:1] == 2'h3) ? WSPE_AMP_STRONG : wspe_amp_t'(rng[2:1]), rng[8:3] % 48);
      end
      // Quiet line: standstill pulse, then recalibration
      rd[15:0] = pulse_cnt;
      n = 0;
      while (current_high !== 1'b1 && n < 1000) begin @(posedge clock); #1 n++; end
      check_rng(since, STOP_T, STOP_T + 3);
      wait_cnt(rd[15:0]);
      check_rng({16'h0000, width}, STOP_P, STOP_P + 2);
      check(speed_valid, 1'b0);
      drive_edge(1'b1, WSPE_AMP_STRONG);
      repeat (CAL + 5) @(posedge clock);
      calibrate();
      pulse(1'b1, WSPE_AMP_STRONG, 20);
      print_verdict();
   end
endmodule // wspe_encoder_tb_top
`default_nettype wire
